// >>> logic/txs_pkg.sv
/*
  Constants shared by the transmitter serial control block: word layout,
  register addresses, field positions and power-up values.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package txs_pkg;
  // Serial word layout: data payload above a four bit address.
  localparam int WORD_BITS = 24;
  localparam int ADDR_BITS = 4;
  localparam int DATA_BITS = 20;
  localparam int DATA_LSB = 4;
  localparam int SYNC_STAGES = 2;

  // Register addresses carried in the low nibble of each word.
  localparam logic [3:0] ADDR_RF_MAIN = 4'h0;
  localparam logic [3:0] ADDR_RF_REF = 4'h1;
  localparam logic [3:0] ADDR_IF_MAIN = 4'h2;
  localparam logic [3:0] ADDR_IF_REF = 4'h3;
  localparam logic [3:0] ADDR_OPERATING_CONTROL = 4'h4;
  localparam logic [3:0] ADDR_CONFIG = 4'h5;
  localparam logic [3:0] ADDR_TEST = 4'h7;

  // Field widths: divider, control and test fields right-justified; pump fields sit at fixed offsets in the configuration word.
  localparam int RF_MAIN_W = 18;
  localparam int RF_REF_W = 13;
  localparam int IF_MAIN_W = 14;
  localparam int IF_REF_W = 11;
  localparam int CTRL_W = 16;
  localparam int TEST_W = 8;
  localparam int PUMP_W = 4;

  // Operating control fields.
  localparam int OP_SOFT_ON = 0;
  localparam int OP_STANDBY_N = 1;
  localparam int OP_BUF_EN = 2;
  localparam int OP_BUF_DIV = 3;
  localparam int OP_IF_BAND_HIGH = 4;
  localparam int OP_IF_PORT_HIGH = 5;

  // Configuration fields.
  localparam int CF_IF_FAST = 0;
  localparam int CF_RF_FAST = 1;
  localparam int CF_LEVEL_SEL = 2;
  localparam int CF_IF_PUMP_LSB = 3;
  localparam int CF_RF_PUMP_LSB = 7;

  // Power-up values.
  localparam logic [RF_MAIN_W-1:0] RST_RF_MAIN = 18'h00000;
  localparam logic [RF_REF_W-1:0] RST_RF_REF = 13'h0000;
  localparam logic [IF_MAIN_W-1:0] RST_IF_MAIN = 14'h0000;
  localparam logic [IF_REF_W-1:0] RST_IF_REF = 11'h000;
  localparam logic [CTRL_W-1:0] RST_OPERATING_CONTROL = 16'h0003;
  localparam logic [CTRL_W-1:0] RST_CONFIG = 16'h0000;
  localparam logic [TEST_W-1:0] RST_TEST = 8'h00;
endpackage : txs_pkg

// >>> logic/txs_fast_lock.sv
/*
  Charge-pump fast-lock controller for one PLL.
  Assumes the phase detector flags arrive as pins from outside the core clock.
*/
`timescale 1ns/1ps
`default_nettype none
module txs_fast_lock (
  // Clock, reset and enable.
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Control from the register bank.
  input wire logic enable,
  input wire logic arm,
  input wire logic [txs_pkg::PUMP_W-1:0] pump_cfg,
  // Phase detector pins.
  input wire logic phase_lead,
  input wire logic freq_locked,
  // Charge pump controls.
  output logic boost,
  output logic [txs_pkg::PUMP_W-1:0] pump_level
);
  import txs_pkg::*;

  typedef struct packed {
    logic [SYNC_STAGES-1:0] lead_sync;
    logic [SYNC_STAGES-1:0] lock_sync;
    logic lead_prev;
    logic flips;
    logic boost;
    logic [PUMP_W-1:0] level;
  } txs_lock_s;

  txs_lock_s st;
  txs_lock_s next_st;
  logic flip_seen;

  ////////////////////////////////////////////////////////////////////////////
  // Boost starts on arm and stops at the second lead/lag flip or at lock.
  always_comb begin
    next_st = st;
    next_st.lead_sync = {st.lead_sync[0], phase_lead};
    next_st.lock_sync = {st.lock_sync[0], freq_locked};
    next_st.level = pump_cfg;
    flip_seen = st.lead_sync[1] != st.lead_prev;
    next_st.lead_prev = st.lead_sync[1];
    if (!enable) begin
      next_st.boost = 1'b0;
      next_st.flips = 1'b0;
    end else if (arm) begin
      next_st.boost = 1'b1;
      next_st.flips = 1'b0;
    end else if (st.boost) begin
      if (st.lock_sync[1]) begin
        next_st.boost = 1'b0;
      end else if (flip_seen) begin
        next_st.flips = 1'b1;
        if (st.flips) begin
          next_st.boost = 1'b0;
        end
      end
    end
  end

  // State register; reset leaves the pump at its power-up level.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  assign boost = st.boost;
  assign pump_level = st.level;

  // Lock must end boost on the next edge unless re-armed.
  turbo_lock_a: assert property (@(posedge clk) disable iff (!rst_n)
    (clk_en && st.boost && st.lock_sync[1] && !arm) |=> !st.boost)
    else $error("boost survived frequency lock");
  // A second flip must end boost.
  turbo_flip_a: assert property (@(posedge clk) disable iff (!rst_n)
    (clk_en && enable && !arm && st.boost && st.flips && flip_seen) |=> !st.boost)
    else $error("boost survived second phase flip");
  // Pump level follows the programmed field.
  pump_level_a: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en |=> pump_level == $past(pump_cfg))
    else $error("pump level differs from programmed current");
endmodule : txs_fast_lock
`default_nettype wire

// >>> logic/txs_serial_regs.sv
/*
  Serially programmed control registers of the transmitter: three-wire
  shift port on its own clock, seven write-only registers, power modes,
  LO buffer and fast-lock control.
  Assumes the host leaves select high for at least four core cycles after
  each word; serial clock edges while select is high are ignored.
*/
`timescale 1ns/1ps
`default_nettype none
module txs_serial_regs (
  // Core clock, reset and enable.
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic clk_en,
  // Three-wire serial port.
  input wire logic serial_clk,
  input wire logic select_n,
  input wire logic serial_data,
  // Power pin.
  input wire logic hard_power_off_n,
  // Analog feedback pins.
  input wire logic if_vco_level,
  input wire logic if_phase_lead,
  input wire logic if_freq_locked,
  input wire logic rf_phase_lead,
  input wire logic rf_freq_locked,
  // Divider ratios.
  output logic [txs_pkg::RF_MAIN_W-1:0] rf_main_count,
  output logic [txs_pkg::RF_REF_W-1:0] rf_reference_count,
  output logic [txs_pkg::IF_MAIN_W-1:0] if_main_count,
  output logic [txs_pkg::IF_REF_W-1:0] if_reference_count,
  // Operating state.
  output logic chip_active,
  output logic buffered_lo_out,
  output logic baseband_level_select,
  output logic if_band_high,
  output logic if_port_high,
  output logic [txs_pkg::TEST_W-1:0] factory_test,
  // Charge pumps.
  output logic if_pump_boost,
  output logic [txs_pkg::PUMP_W-1:0] if_pump_current,
  output logic rf_pump_boost,
  output logic [txs_pkg::PUMP_W-1:0] rf_pump_current
);
  import txs_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Reset release.

  logic [1:0] rst_sync;
  logic rst_n;

  // Asynchronous assertion, synchronous release of the core reset.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  ////////////////////////////////////////////////////////////////////////////
  // Serial clock domain: shift register only.

  typedef struct packed {
    logic [WORD_BITS-1:0] shift;
  } txs_link_s;

  txs_link_s lk;
  txs_link_s next_lk;

  // Shift while selected; with select high the word stays put for the core.
  always_comb begin
    next_lk = lk;
    if (!select_n) begin
      next_lk.shift = {lk.shift[WORD_BITS-2:0], serial_data};
    end
  end

  // Raw nrst here: the serial clock may be stopped when reset is released.
  always_ff @(posedge serial_clk or negedge nrst) begin
    if (!nrst) begin
      lk <= '0;
    end else begin
      lk <= next_lk;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Core clock domain state.

  typedef struct packed {
    logic [SYNC_STAGES:0] sel_sync;
    logic [SYNC_STAGES-1:0] hard_sync;
    logic [SYNC_STAGES:0] vco_sync;
    logic [RF_MAIN_W-1:0] rf_main;
    logic [RF_REF_W-1:0] rf_ref;
    logic [IF_MAIN_W-1:0] if_main;
    logic [IF_REF_W-1:0] if_ref;
    logic [CTRL_W-1:0] operating_control;
    logic [CTRL_W-1:0] config_bits;
    logic [TEST_W-1:0] test;
    logic if_arm;
    logic rf_arm;
    logic active;
    logic lo_out;
  } txs_core_s;

  txs_core_s st;
  txs_core_s next_st;
  logic word_done;
  logic [ADDR_BITS-1:0] word_addr;
  logic [DATA_BITS-1:0] word_data;
  logic next_on;

  // The word is stable by the time select's rise has crossed two flops.
  assign word_done = st.sel_sync[1] && !st.sel_sync[2] && st.hard_sync[1];
  assign word_addr = lk.shift[ADDR_BITS-1:0];
  assign word_data = lk.shift[WORD_BITS-1:DATA_LSB];

  // Register writes, power modes and the LO buffer.
  always_comb begin
    next_st = st;
    next_st.sel_sync = {st.sel_sync[SYNC_STAGES-1:0], select_n};
    next_st.hard_sync = {st.hard_sync[0], hard_power_off_n};
    next_st.vco_sync = {st.vco_sync[SYNC_STAGES-1:0], if_vco_level};
    next_st.if_arm = 1'b0;
    next_st.rf_arm = 1'b0;
    if (!st.hard_sync[1]) begin
      next_st.rf_main = RST_RF_MAIN;
      next_st.rf_ref = RST_RF_REF;
      next_st.if_main = RST_IF_MAIN;
      next_st.if_ref = RST_IF_REF;
      next_st.operating_control = RST_OPERATING_CONTROL;
      next_st.config_bits = RST_CONFIG;
      next_st.test = RST_TEST;
    end else if (word_done) begin
      case (word_addr)
        ADDR_RF_MAIN: begin
          next_st.rf_main = word_data[RF_MAIN_W-1:0];
          next_st.rf_arm = 1'b1;
        end
        ADDR_RF_REF: begin
          next_st.rf_ref = word_data[RF_REF_W-1:0];
          next_st.rf_arm = 1'b1;
        end
        ADDR_IF_MAIN: begin
          next_st.if_main = word_data[IF_MAIN_W-1:0];
          next_st.if_arm = 1'b1;
        end
        ADDR_IF_REF: begin
          next_st.if_ref = word_data[IF_REF_W-1:0];
          next_st.if_arm = 1'b1;
        end
        ADDR_OPERATING_CONTROL: begin
          if (!word_data[OP_SOFT_ON]) begin
            next_st.rf_main = RST_RF_MAIN;
            next_st.rf_ref = RST_RF_REF;
            next_st.if_main = RST_IF_MAIN;
            next_st.if_ref = RST_IF_REF;
            next_st.config_bits = RST_CONFIG;
            next_st.test = RST_TEST;
          end
          next_st.operating_control = word_data[CTRL_W-1:0];
        end
        ADDR_CONFIG: begin
          next_st.config_bits = word_data[CTRL_W-1:0];
          next_st.if_arm = 1'b1;
          next_st.rf_arm = 1'b1;
        end
        ADDR_TEST: begin
          next_st.test = word_data[TEST_W-1:0];
        end
        default: begin
          next_st.test = st.test;
        end
      endcase
    end
    // Standby keeps registers but powers the part down.
    next_on = st.hard_sync[1] && st.operating_control[OP_SOFT_ON] && st.operating_control[OP_STANDBY_N];
    next_st.active = next_on;
    // Buffer output: follow the VCO or toggle on each of its rises.
    if (!(st.active && st.operating_control[OP_BUF_EN])) begin
      next_st.lo_out = 1'b0;
    end else if (!st.operating_control[OP_BUF_DIV]) begin
      next_st.lo_out = st.vco_sync[1];
    end else if (st.vco_sync[1] && !st.vco_sync[2]) begin
      next_st.lo_out = !st.lo_out;
    end
  end

  // Power-up values make every register defined before any write.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '{sel_sync: '1, hard_sync: '0, vco_sync: '0, rf_main: RST_RF_MAIN,
              rf_ref: RST_RF_REF, if_main: RST_IF_MAIN, if_ref: RST_IF_REF,
              operating_control: RST_OPERATING_CONTROL, config_bits: RST_CONFIG, test: RST_TEST,
              if_arm: 1'b0, rf_arm: 1'b0, active: 1'b0, lo_out: 1'b0};
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fast-lock controllers, one per PLL.

  logic [1:0] fl_enable;
  logic [1:0] fl_arm;
  logic [PUMP_W-1:0] fl_cfg [2];
  logic [1:0] fl_lead;
  logic [1:0] fl_lock;
  logic [1:0] fl_boost;
  logic [PUMP_W-1:0] fl_level [2];

  // Index 0 is the IF loop, index 1 the RF loop.
  assign fl_enable = {st.config_bits[CF_RF_FAST], st.config_bits[CF_IF_FAST]} & {2{st.active}};
  assign fl_arm = {st.rf_arm, st.if_arm};
  assign fl_cfg[0] = st.config_bits[CF_IF_PUMP_LSB +: PUMP_W];
  assign fl_cfg[1] = st.config_bits[CF_RF_PUMP_LSB +: PUMP_W];
  assign fl_lead = {rf_phase_lead, if_phase_lead};
  assign fl_lock = {rf_freq_locked, if_freq_locked};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_pll
      txs_fast_lock u_lock (
        .clk(core_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .enable(fl_enable[gi]),
        .arm(fl_arm[gi]),
        .pump_cfg(fl_cfg[gi]),
        .phase_lead(fl_lead[gi]),
        .freq_locked(fl_lock[gi]),
        .boost(fl_boost[gi]),
        .pump_level(fl_level[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all taken from state flops.

  assign rf_main_count = st.rf_main;
  assign rf_reference_count = st.rf_ref;
  assign if_main_count = st.if_main;
  assign if_reference_count = st.if_ref;
  assign chip_active = st.active;
  assign buffered_lo_out = st.lo_out;
  assign baseband_level_select = st.config_bits[CF_LEVEL_SEL];
  assign if_band_high = st.operating_control[OP_IF_BAND_HIGH];
  assign if_port_high = st.operating_control[OP_IF_PORT_HIGH];
  assign factory_test = st.test;
  assign if_pump_boost = fl_boost[0];
  assign if_pump_current = fl_level[0];
  assign rf_pump_boost = fl_boost[1];
  assign rf_pump_current = fl_level[1];

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  // A word addressed to the RF main divider lands in it.
  rf_main_write_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (clk_en && word_done && word_addr == ADDR_RF_MAIN) |=> rf_main_count == $past(word_data[RF_MAIN_W-1:0]))
    else $error("rf main divider not loaded from word");
  // A word addressed to the IF reference divider lands in it.
  if_ref_write_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (clk_en && word_done && word_addr == ADDR_IF_REF) |=> if_reference_count == $past(word_data[IF_REF_W-1:0]))
    else $error("if reference divider not loaded from word");
  // An unmapped address changes nothing.
  unused_addr_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (clk_en && word_done && word_addr == 4'h6) |=> $stable(st.rf_main) && $stable(st.operating_control) && $stable(st.test))
    else $error("unmapped address changed a register");
  // Soft power-off clears the dividers.
  soft_off_clear_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (clk_en && word_done && word_addr == ADDR_OPERATING_CONTROL && !word_data[OP_SOFT_ON])
      |=> rf_main_count == RST_RF_MAIN && if_main_count == RST_IF_MAIN)
    else $error("soft power-off kept divider contents");
  // Hard power-off clears registers and ends activity within two edges.
  hard_off_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (clk_en && !st.hard_sync[1]) ##1 (clk_en && !st.hard_sync[1]) |=> st.test == RST_TEST && !chip_active)
    else $error("hard power-off left part active");
  // Standby powers down but keeps the dividers.
  standby_keep_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (clk_en && !st.operating_control[OP_STANDBY_N] && st.hard_sync[1] && !word_done) |=> !chip_active && $stable(rf_main_count))
    else $error("standby lost registers or stayed active");
  // The LO buffer stays quiet while disabled.
  lo_disabled_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (clk_en && !(st.active && st.operating_control[OP_BUF_EN])) |=> !buffered_lo_out)
    else $error("buffered LO ran while disabled");
  // Undivided buffer follows the synchronised VCO level.
  lo_follow_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (clk_en && st.active && st.operating_control[OP_BUF_EN] && !st.operating_control[OP_BUF_DIV]) |=> buffered_lo_out == $past(st.vco_sync[1]))
    else $error("undivided LO does not follow VCO");
  // A configuration word sets the baseband level select bit.
  cfg_write_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (clk_en && word_done && word_addr == ADDR_CONFIG) |=> baseband_level_select == $past(word_data[CF_LEVEL_SEL]))
    else $error("level select not loaded from word");
  // A word addressed to the test register lands in it.
  test_write_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (clk_en && word_done && word_addr == ADDR_TEST) |=> factory_test == $past(word_data[TEST_W-1:0]))
    else $error("test register not loaded from word");
  // Pin high, soft-on and not standby make the part active.
  active_on_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (clk_en && st.hard_sync[1] && st.operating_control[OP_SOFT_ON] && st.operating_control[OP_STANDBY_N]) |=> chip_active)
    else $error("part stayed inactive while powered on");
  // Serial data enters the shift register while selected.
  shift_in_a: assert property (@(posedge serial_clk) disable iff (!nrst)
    !select_n |=> lk.shift[0] == $past(serial_data) && lk.shift[WORD_BITS-1:1] == $past(lk.shift[WORD_BITS-2:0]))
    else $error("serial bit not shifted in");
  // Deselected clock edges leave the word alone.
  select_hold_a: assert property (@(posedge serial_clk) disable iff (!nrst)
    select_n |=> $stable(lk.shift))
    else $error("shift register moved while deselected");
endmodule : txs_serial_regs
`default_nettype wire

// >>> tb/txs_host_model.sv
/*
  Behavioural host that frames words on the three-wire serial port.
  Assumes the bench raises start for one core cycle and then waits for busy to fall.
*/
`timescale 1ns/1ps
`default_nettype none
module txs_host_model (
  // Pacing clock and request.
  input wire logic core_clk,
  input wire logic start,
  input wire logic [31:0] word,
  input wire logic [5:0] nbits,
  output logic busy,
  // Three-wire serial port.
  output logic serial_clk,
  output logic select_n,
  output logic serial_data
);
  //////////////////////////////////////////////////////////////////////////////
  // One frame per request, with a 48 ns link clock that pulses twice while deselected after each frame.
  initial begin
    busy = 1'b0;
    serial_clk = 1'b0;
    select_n = 1'b1;
    serial_data = 1'b0;
    forever begin
      @(posedge core_clk);
      if (start) begin
        busy = 1'b1;
        // The odd offset keeps the link clock out of phase with the core clock.
        #3;
        select_n = 1'b0;
        // Highest bit leaves first, so the address nibble goes out last.
        for (int i = nbits - 1; i >= 0; i--) begin
          serial_data = word[i];
          #24 serial_clk = 1'b1;
          #24 serial_clk = 1'b0;
        end
        #24 select_n = 1'b1;
        // A released line must not keep showing the last bit.
        serial_data = ~serial_data;
        // Select stays high and quiet until the core has taken the word.
        repeat (8) @(posedge core_clk);
        // Stray edges while deselected must leave the held word alone.
        repeat (2) begin
          serial_data = ~serial_data;
          #24 serial_clk = 1'b1;
          #24 serial_clk = 1'b0;
        end
        @(negedge core_clk);
        busy = 1'b0;
      end
    end
  end
endmodule : txs_host_model
`default_nettype wire

// >>> tb/txs_serial_regs_tb.sv
/*
  Self-checking bench for the serial control registers.
  Assumes the host model in txs_host_model.sv and the design package.
*/
`timescale 1ns/1ps
`default_nettype none
module txs_serial_regs_tb;
  import txs_pkg::*;
  logic nrst, serial_clk, select_n, serial_data, hard_power_off_n, clk_en;
  logic core_clk = 1'b0;
  logic if_vco_level = 1'b0;
  logic lo_q = 1'b0;
  logic if_phase_lead, if_freq_locked, rf_phase_lead, rf_freq_locked, start, busy;
  logic chip_active, buffered_lo_out, baseband_level_select, if_band_high, if_port_high;
  logic if_pump_boost, rf_pump_boost;
  logic [31:0] word;
  logic [5:0] nbits;
  logic [2:0] vco_cnt = 3'h0;
  logic [RF_MAIN_W-1:0] rf_main_count;
  logic [RF_REF_W-1:0] rf_reference_count;
  logic [IF_MAIN_W-1:0] if_main_count;
  logic [IF_REF_W-1:0] if_reference_count;
  logic [TEST_W-1:0] factory_test;
  logic [PUMP_W-1:0] if_pump_current, rf_pump_current;
  logic [19:0] pay [5] = '{20'hfa5a5, 20'hfffff, 20'h5c3a7, 20'h3e9b6, 20'hfff5a};
  logic [3:0] adr [5] = '{ADDR_RF_MAIN, ADDR_RF_REF, ADDR_IF_MAIN, ADDR_IF_REF, ADDR_TEST};
  logic [19:0] lo_op [3] = '{20'h00003, 20'h00007, 20'h0000f};
  int lo_min [3] = '{0, 7, 3};
  int lo_max [3] = '{0, 9, 5};
  int num_errors, cmp_count, lo_rises, n0;

  txs_serial_regs DUT (.core_clk, .nrst, .clk_en, .serial_clk, .select_n, .serial_data,
    .hard_power_off_n, .if_vco_level, .if_phase_lead, .if_freq_locked, .rf_phase_lead,
    .rf_freq_locked, .rf_main_count, .rf_reference_count, .if_main_count, .if_reference_count,
    .chip_active, .buffered_lo_out, .baseband_level_select, .if_band_high, .if_port_high,
    .factory_test, .if_pump_boost, .if_pump_current, .rf_pump_boost, .rf_pump_current);
  txs_host_model host (.core_clk, .start, .word, .nbits, .busy, .serial_clk, .select_n, .serial_data);

  //////////////////////////////////////////////////////////////////////////////
  // Clock, a VCO square wave of eight core cycles, and a count of LO rising edges.
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    vco_cnt <= vco_cnt + 3'h1;
    if_vco_level <= vco_cnt[2];
    lo_q <= buffered_lo_out;
    if (buffered_lo_out === 1'b1 && lo_q === 1'b0) lo_rises <= lo_rises + 1;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Shared tasks for comparison and serial traffic.
  task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic xfer(input logic [31:0] w, input logic [5:0] n);
    int k;
    @(posedge core_clk);
    start <= 1'b1;
    word <= w;
    nbits <= n;
    @(posedge core_clk);
    start <= 1'b0;
    @(posedge core_clk);
    k = 0;
    // A bounded wait, so a stuck host cannot hang the run.
    while (busy !== 1'b0 && k < 2000) begin
      @(posedge core_clk);
      k++;
    end
    if (k == 2000) chk("host_busy", 24'h0, 24'h1);
  endtask : xfer
  task automatic wr(input logic [3:0] a, input logic [19:0] p);
    xfer({8'h00, p, a}, 6'd24);
  endtask : wr
  task automatic cnts(input logic [23:0] a, input logic [23:0] b, input logic [23:0] c, input logic [23:0] d);
    chk("rf_main_count", a, 24'(rf_main_count));
    chk("rf_reference_count", b, 24'(rf_reference_count));
    chk("if_main_count", c, 24'(if_main_count));
    chk("if_reference_count", d, 24'(if_reference_count));
  endtask : cnts
  task automatic print_verdict;
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict

  //////////////////////////////////////////////////////////////////////////////
  // Watchdog sized well above the roughly 3800 cycles the tests need.
  initial begin
    repeat (30000) @(posedge core_clk);
    chk("watchdog", 24'h0, 24'h1);
    print_verdict();
  end

  //////////////////////////////////////////////////////////////////////////////
  // Test sequence.
  initial begin
    {nrst, start, word, nbits} = '0;
    {if_phase_lead, if_freq_locked, rf_phase_lead, rf_freq_locked} = '0;
    hard_power_off_n = 1'b1;
    clk_en = 1'b1;
    num_errors = 0;
    cmp_count = 0;
    repeat (3) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (8) @(posedge core_clk);
    cnts(0, 0, 0, 0);
    chk("state", 24'h1, 24'({factory_test, buffered_lo_out, baseband_level_select, if_band_high, if_port_high,
      if_pump_boost, rf_pump_boost, if_pump_current, rf_pump_current, chip_active}));
    $display("test reset done");
    for (int j = 0; j < 5; j++) wr(adr[j], pay[j]);
    cnts(pay[0][RF_MAIN_W-1:0], pay[1][RF_REF_W-1:0], pay[2][IF_MAIN_W-1:0], pay[3][IF_REF_W-1:0]);
    chk("factory_test", 24'(pay[4][TEST_W-1:0]), 24'(factory_test));
    wr(4'h6, 20'h11111);
    wr(4'h8, 20'h22222);
    wr(4'hf, 20'h33333);
    cnts(pay[0][RF_MAIN_W-1:0], pay[1][RF_REF_W-1:0], pay[2][IF_MAIN_W-1:0], pay[3][IF_REF_W-1:0]);
    $display("test dividers done");
    xfer(32'h123451, 6'd24);
    xfer(32'h671, 6'd12);
    chk("short_frame", 24'h1167, 24'(rf_reference_count));
    xfer(32'h9234562, 6'd28);
    chk("long_frame", 24'h3456, 24'(if_main_count));
    $display("test framing done");
    wr(ADDR_CONFIG, 20'h0034c);
    chk("config", 24'h196, 24'({baseband_level_select, if_pump_current, rf_pump_current}));
    wr(ADDR_OPERATING_CONTROL, 20'h00013);
    chk("band_port", 24'h2, 24'({if_band_high, if_port_high}));
    wr(ADDR_OPERATING_CONTROL, 20'h00023);
    chk("band_port", 24'h1, 24'({if_band_high, if_port_high}));
    for (int j = 0; j < 3; j++) begin
      wr(ADDR_OPERATING_CONTROL, lo_op[j]);
      n0 = lo_rises;
      repeat (64) @(posedge core_clk);
      n0 = lo_rises - n0;
      chk("lo_rises_in_range", 24'h1, {23'h0, n0 >= lo_min[j] && n0 <= lo_max[j]});
    end
    $display("test control done");
    wr(ADDR_CONFIG, 20'h00302);
    chk("rf_boost", 24'h1, 24'(rf_pump_boost));
    rf_phase_lead <= 1'b1;
    repeat (8) @(posedge core_clk);
    chk("rf_boost_one_change", 24'h1, 24'(rf_pump_boost));
    rf_phase_lead <= 1'b0;
    repeat (8) @(posedge core_clk);
    chk("rf_boost_end", 24'h06, 24'({rf_pump_boost, rf_pump_current}));
    wr(ADDR_CONFIG, 20'h00049);
    chk("if_boost", 24'h32, 24'({if_pump_boost, if_pump_current, baseband_level_select}));
    if_freq_locked <= 1'b1;
    repeat (8) @(posedge core_clk);
    chk("if_boost_end", 24'h09, 24'({if_pump_boost, if_pump_current}));
    if_freq_locked <= 1'b0;
    $display("test fast lock done");
    wr(ADDR_OPERATING_CONTROL, 20'h00001);
    chk("standby", 24'(pay[0][RF_MAIN_W-1:0]), 24'({chip_active, rf_main_count}));
    wr(ADDR_OPERATING_CONTROL, 20'h00000);
    chk("soft_off", 24'h0, 24'({chip_active, rf_main_count}));
    chk("soft_off_ref", 24'h0, 24'(rf_reference_count));
    wr(ADDR_OPERATING_CONTROL, 20'h00003);
    chk("soft_on", 24'h1, 24'(chip_active));
    wr(ADDR_RF_MAIN, 20'h00123);
    hard_power_off_n <= 1'b0;
    repeat (6) @(posedge core_clk);
    chk("hard_off", 24'h0, 24'({chip_active, rf_main_count}));
    wr(ADDR_RF_MAIN, 20'h00456);
    hard_power_off_n <= 1'b1;
    repeat (8) @(posedge core_clk);
    chk("hard_on", 24'h40000, 24'({chip_active, rf_main_count}));
    // A frozen core misses the select rise, so that word never lands.
    clk_en <= 1'b0;
    wr(ADDR_TEST, 20'h000aa);
    clk_en <= 1'b1;
    repeat (4) @(posedge core_clk);
    chk("frozen_write", 24'h0, 24'(factory_test));
    wr(ADDR_TEST, 20'h000aa);
    chk("factory_test", 24'haa, 24'(factory_test));
    $display("test power done");
    print_verdict();
  end
endmodule : txs_serial_regs_tb
`default_nettype wire
